// >>> hw/ocp_hiccup.sv
// Second-level overcurrent protection with hiccup restart.
// Assumes analog comparators supply the flags as asynchronous levels and the
// oscillator gives a cycle-start level that rises once per switching cycle.
//
// Operation
// - A cycle is tripped when drain current exceeds the second-level limit.
// - First tripped cycle from idle enters warning; switch stays enabled.
// - Untripped cycle after warning returns logic to idle.
// - Two consecutive tripped cycles declare fault and turn switch off.
// - Shutdown is latched while supplied; switching inhibited while latched.
// - Disabled device transfers no energy; supply undervoltage clears the latch.
// - Startup source stays off until supply below restart, then recharges.
// - Switching resumes when recharged supply reaches turn-on threshold.
// - Persistent fault repeats shutdown and restart indefinitely.
// - Restart near 4.5 V, turn-on near 14 V; recharge by source.
`timescale 1ns/100ps
module ocp_hiccup
  import ocp_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic CYCLE_START_I,
  input wire logic OVER_LIMIT_I,
  input wire logic SUPPLY_UNDERVOLTAGE_I,
  input wire logic SUPPLY_BELOW_RESTART_I,
  input wire logic SUPPLY_TURN_ON_I,
  output logic SWITCH_ENABLE_O,
  output logic STARTUP_SOURCE_ON_O,
  output logic WARNING_O,
  output logic FAULT_LATCHED_O
);

  // ------------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------------
  ocp_flags_t raw;
  ocp_flags_t flg;

  assign raw = '{cycle_start: CYCLE_START_I, over_limit: OVER_LIMIT_I,
                 supply_undervoltage: SUPPLY_UNDERVOLTAGE_I,
                 supply_below_restart: SUPPLY_BELOW_RESTART_I,
                 supply_turn_on: SUPPLY_TURN_ON_I};

  ocp_sync #(
    .WIDTH($bits(ocp_flags_t))
  ) u_sync (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .async_i(raw),
    .sync_o(flg)
  );

  // ------------------------------------------------------------------
  // Cycle boundary and per-cycle trip capture
  // ------------------------------------------------------------------
  logic cyc_q;
  logic trip_seen_q;
  logic cycle_edge;
  ocp_state_t state_q;
  ocp_state_t state_d;

  assign cycle_edge = flg.cycle_start && !cyc_q;

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cyc_q <= 1'b0;
    end else begin
      cyc_q <= flg.cycle_start;
    end
  end

  // A trip anywhere in the cycle counts, so a short spike is not missed
  // between cycle edges; the record restarts at each boundary.
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      trip_seen_q <= 1'b0;
    end else if (cycle_edge) begin
      trip_seen_q <= flg.over_limit;
    end else if (flg.over_limit) begin
      trip_seen_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Protection sequencer
  // ------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      OCP_IDLE: begin
        if (cycle_edge && trip_seen_q) begin
          state_d = OCP_WARN;
        end
      end
      OCP_WARN: begin
        if (cycle_edge) begin
          if (trip_seen_q) begin
            state_d = OCP_LATCHED;
          end else begin
            state_d = OCP_IDLE;
          end
        end
      end
      OCP_LATCHED: begin
        if (flg.supply_undervoltage) begin
          state_d = OCP_DISCHARGE;
        end
      end
      OCP_DISCHARGE: begin
        if (flg.supply_below_restart) begin
          state_d = OCP_RECHARGE;
        end
      end
      OCP_RECHARGE: begin
        if (flg.supply_turn_on) begin
          state_d = OCP_IDLE;
        end
      end
      default: begin
        state_d = OCP_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_q <= OCP_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, registered from the next state
  // ------------------------------------------------------------------
  // Switch is held off from reset until the first state update, one clock, so it
  // turns on before the two-stage synchroniser has filled.
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      SWITCH_ENABLE_O <= 1'b0;
      STARTUP_SOURCE_ON_O <= 1'b0;
      WARNING_O <= 1'b0;
      FAULT_LATCHED_O <= 1'b0;
    end else begin
      SWITCH_ENABLE_O <= (state_d == OCP_IDLE) || (state_d == OCP_WARN);
      STARTUP_SOURCE_ON_O <= (state_d == OCP_RECHARGE);
      WARNING_O <= (state_d == OCP_WARN);
      FAULT_LATCHED_O <= (state_d == OCP_LATCHED);
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_trip_cycle;
    cycle_edge && trip_seen_q;
  endsequence

  sequence s_first_trip;
    (state_q == OCP_IDLE) ##0 s_trip_cycle;
  endsequence

  sequence s_second_trip;
    (state_q == OCP_WARN) ##0 s_trip_cycle;
  endsequence

  // Cycle starts are at least two clocks apart; a slower oscillator only
  // leaves this window unmatched, it never makes the check fire falsely.
  sequence s_two_trips;
    s_first_trip ##[2:1000] s_second_trip;
  endsequence

  chk_warn_keeps_on: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (state_q == OCP_IDLE) && cycle_edge && trip_seen_q |=> ##0 SWITCH_ENABLE_O && WARNING_O)
    else $error("first trip must warn without shutdown");

  chk_warn_to_idle: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (state_q == OCP_WARN) && cycle_edge && !trip_seen_q |=> state_q == OCP_IDLE)
    else $error("clean cycle after warning must return to idle");

  chk_fault_shutdown: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    s_second_trip |=> FAULT_LATCHED_O && !SWITCH_ENABLE_O)
    else $error("second trip must shut the switch off");

  chk_two_trip_fault: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    s_two_trips |=> FAULT_LATCHED_O && !WARNING_O && !STARTUP_SOURCE_ON_O)
    else $error("two consecutive trips must latch the fault");

  chk_latch_holds: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (state_q == OCP_LATCHED) && !flg.supply_undervoltage |=> state_q == OCP_LATCHED)
    else $error("latch released without undervoltage");

  chk_latch_clear: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (state_q == OCP_LATCHED) && flg.supply_undervoltage |=> !FAULT_LATCHED_O ##0 !SWITCH_ENABLE_O)
    else $error("undervoltage must clear latch while staying off");

  chk_source_wait: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (state_q == OCP_DISCHARGE) && !flg.supply_below_restart |=> !STARTUP_SOURCE_ON_O)
    else $error("startup source on before restart level");

  chk_source_on: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (state_q == OCP_DISCHARGE) && flg.supply_below_restart |=> STARTUP_SOURCE_ON_O [*1] ##0 !SWITCH_ENABLE_O)
    else $error("startup source must start below restart level");

  chk_resume: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (state_q == OCP_RECHARGE) && flg.supply_turn_on |=> SWITCH_ENABLE_O && !STARTUP_SOURCE_ON_O)
    else $error("switching must resume at turn-on level");

  chk_off_when_disabled: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    $rose(FAULT_LATCHED_O) |-> !SWITCH_ENABLE_O throughout (!STARTUP_SOURCE_ON_O [*2]))
    else $error("switch on during shutdown");

  chk_cycle_sync: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    !cycle_edge && (state_q == OCP_IDLE || state_q == OCP_WARN) |=> $stable(state_q))
    else $error("trip state moved between cycle starts");

endmodule

// >>> hw/ocp_pkg.sv
// Package for the second-level overcurrent hiccup protection block.
// Assumes one 250 MHz system clock; all comparator flags are asynchronous pins.
package ocp_pkg;

  // ------------------------------------------------------------------
  // Clock and synchroniser
  // ------------------------------------------------------------------
  localparam int OCP_CLOCK_MHZ = 250;
  localparam int OCP_SYNC_STAGES = 2;

  // ------------------------------------------------------------------
  // Supply thresholds in millivolts, kept for reference only; neither the block nor the bench reads them
  // ------------------------------------------------------------------
  localparam int OCP_RESTART_MV = 4500;
  localparam int OCP_TURN_ON_MV = 14000;

  // ------------------------------------------------------------------
  // Trip counting
  // ------------------------------------------------------------------
  localparam logic [1:0] OCP_TRIPS_TO_FAULT = 2'h2;
  localparam logic [1:0] OCP_TRIPS_NONE = 2'h0;

  // ------------------------------------------------------------------
  // Protection state and flag bundle
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    OCP_IDLE,
    OCP_WARN,
    OCP_LATCHED,
    OCP_DISCHARGE,
    OCP_RECHARGE
  } ocp_state_t;

  typedef struct packed {
    logic cycle_start;
    logic over_limit;
    logic supply_undervoltage;
    logic supply_below_restart;
    logic supply_turn_on;
  } ocp_flags_t;

endpackage

// >>> hw/ocp_sync.sv
// Two flip-flop synchroniser, one per bit of a flag vector.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/100ps
module ocp_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        meta_q[g] <= 1'b0;
        sync_o[g] <= 1'b0;
      end else begin
        meta_q[g] <= async_i[g];
        sync_o[g] <= meta_q[g];
      end
    end
  end

endmodule

// >>> verification/testbench.sv
// Self-checking bench for the overcurrent hiccup protection block.
// Assumes the block's own assertions run inside it; the bench drives every pin.
`timescale 1ns/100ps
module testbench;
  import ocp_pkg::*;

  // ------------------------------------------------------------------
  // Clock, pins and counters
  // ------------------------------------------------------------------
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cyc_start = 1'h0;
  logic over = 1'h0;
  logic uv = 1'h0;
  logic below = 1'h0;
  logic turn_on = 1'h0;
  logic sw_en;
  logic src_on;
  logic warn;
  logic fault;
  int err_total = 0;
  int checks = 0;

  initial begin
    forever #2 clk = ~clk;
  end

  ocp_hiccup dut (
    .CLOCK_I(clk),
    .RESET_I(rst),
    .CYCLE_START_I(cyc_start),
    .OVER_LIMIT_I(over),
    .SUPPLY_UNDERVOLTAGE_I(uv),
    .SUPPLY_BELOW_RESTART_I(below),
    .SUPPLY_TURN_ON_I(turn_on),
    .SWITCH_ENABLE_O(sw_en),
    .STARTUP_SOURCE_ON_O(src_on),
    .WARNING_O(warn),
    .FAULT_LATCHED_O(fault)
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Outputs are looked at mid-cycle, where they are settled, and the task
  // returns on a rising edge so the next drive still lands on the edge.
  task automatic outs(input logic e_sw, input logic e_src, input logic e_w, input logic e_f);
    @(negedge clk);
    chk("switch_enable", e_sw, sw_en);
    chk("startup_source", e_src, src_on);
    chk("warning", e_w, warn);
    chk("fault_latched", e_f, fault);
    @(posedge clk);
  endtask

  // One switching cycle; the trip is raised clear of both boundary edges so
  // it lands in this cycle's record only. Outputs reflect the previous record.
  task automatic cyc(input logic trip);
    cyc_start <= 1'h1;
    repeat (2) @(posedge clk);
    over <= trip;
    repeat (4) @(posedge clk);
    cyc_start <= 1'h0;
    over <= 1'h0;
    repeat (8) @(posedge clk);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_disturbance();
    cyc(1'h0);
    cyc(1'h1);
    outs(1'h1, 1'h0, 1'h0, 1'h0);
    cyc(1'h0);
    outs(1'h1, 1'h0, 1'h1, 1'h0);
    cyc(1'h0);
    outs(1'h1, 1'h0, 1'h0, 1'h0);
  endtask

  task automatic t_hiccup();
    cyc(1'h1);
    cyc(1'h1);
    outs(1'h1, 1'h0, 1'h1, 1'h0);
    cyc(1'h0);
    outs(1'h0, 1'h0, 1'h0, 1'h1);
    below <= 1'h1;
    cyc(1'h1);
    cyc(1'h0);
    outs(1'h0, 1'h0, 1'h0, 1'h1);
    below <= 1'h0;
    uv <= 1'h1;
    step(8);
    outs(1'h0, 1'h0, 1'h0, 1'h0);
    below <= 1'h1;
    step(8);
    outs(1'h0, 1'h1, 1'h0, 1'h0);
    uv <= 1'h0;
    below <= 1'h0;
    turn_on <= 1'h1;
    step(8);
    outs(1'h1, 1'h0, 1'h0, 1'h0);
    turn_on <= 1'h0;
    step(4);
  endtask

  // A reset in mid-run clears a latched fault and restarts from idle
  task automatic t_reset_latched();
    cyc(1'h1);
    cyc(1'h1);
    cyc(1'h0);
    outs(1'h0, 1'h0, 1'h0, 1'h1);
    rst <= 1'h1;
    step(2);
    outs(1'h0, 1'h0, 1'h0, 1'h0);
    rst <= 1'h0;
    step(3);
    outs(1'h1, 1'h0, 1'h0, 1'h0);
    step(4);
  endtask

  // ------------------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    step(20);
    rst <= 1'h0;
    step(3);
    outs(1'h1, 1'h0, 1'h0, 1'h0);
    t_disturbance();
    t_hiccup();
    // A fault that persists goes round the same loop again
    t_hiccup();
    t_reset_latched();
    test_done();
  end

  initial begin
    #20000;
    err_total++;
    test_done();
  end
endmodule
